// ### rtl/acs_pkg.sv
package acs_pkg;
    localparam int ACS_ADDR_W = 5;
    localparam int ACS_BYTE_W = 8;
    localparam int ACS_CELL_LEN = 53;
    localparam logic [4:0] ACS_MY_ADDR = 5'h01;
    localparam logic [4:0] ACS_NULL_ADDR = 5'h1F;
    localparam logic [7:0] ACS_IDLE_BYTE = 8'h00;

    // Cell byte offered by the core side
    typedef struct packed {
        logic sop;
        logic [7:0] data;
    } acs_byte_t;

    // Pins facing the master
    typedef struct packed {
        logic ready;
        logic soc;
        logic [7:0] data;
    } acs_link_out_t;
endpackage

// ### rtl/acs_tx_port.sv
`timescale 1ns/1ps
// Operation
// - Cell-ready output high only while a complete cell is ready.
// - Cycle after enable sampled: first byte and start-of-cell driven.
// - Start-of-cell updated on clock rise, high only with first byte.
// - Strap low: port inactive, outputs tied off.
// - Upper address bits shared with serial port; address only when strap high.
module acs_tx_port #(
    parameter int CELL_LEN = acs_pkg::ACS_CELL_LEN,
    parameter logic [4:0] MY_ADDR = acs_pkg::ACS_MY_ADDR
) (
    input wire logic i_mclk,                    // Core clock
    input wire logic i_sys_rst,                 // Async reset, high
    input wire logic i_ce,                      // Clock enable
    input wire logic i_cell_port_enable_strap,  // Port strap
    input wire logic i_cell_load,               // Core: cell complete, pulse
    input wire acs_pkg::acs_byte_t i_cell_byte, // Core byte (read by index)
    output logic [5:0] o_cell_rd_idx,           // Byte index wanted
    output logic o_cell_taken,                  // Cell drained, toggle
    input wire logic i_tx_cell_clock,           // Link clock from master
    input wire logic i_tx_transfer_enable_n,    // Enable from master, low
    input wire logic [4:0] i_tx_slave_select_addr, // Address pins
    output acs_pkg::acs_link_out_t o_link,      // Ready, SOC, data
    output logic o_link_oe_n,                   // Link output enable, low
    output logic o_serial_port_one_sel          // Upper addr pins to serial
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // Core domain: strap synchroniser
    // ------------------------------------------------------------
    logic strap_s1;
    logic strap_s2;
    logic strap_arm1;
    logic strap_arm2;
    logic strap;
    logic strap_done;
    logic cell_tgl;
    logic take_s1, take_s2, take_s3;

    // Two flops between the strap pin and any logic
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else if (i_ce) begin
            strap_s1 <= i_cell_port_enable_strap;
            strap_s2 <= strap_s1;
        end
    end

    // Arm chain: capture only once the synchroniser holds a pin value
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap_arm1 <= 1'b0;
            strap_arm2 <= 1'b0;
        end else if (i_ce) begin
            strap_arm1 <= 1'b1;
            strap_arm2 <= strap_arm1;
        end
    end

    // ------------------------------------------------------------
    // Core domain: strap capture
    // ------------------------------------------------------------
    // Boot setting: sampled once, then frozen until reset
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap <= 1'b0;
            strap_done <= 1'b0;
        end else if (i_ce && strap_arm2 && !strap_done) begin
            strap <= strap_s2;
            strap_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Core domain: pin function select
    // ------------------------------------------------------------
    // Serial function by default, address only with strap high
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_serial_port_one_sel <= 1'b1;
        end else if (i_ce) begin
            o_serial_port_one_sel <= !strap;
        end
    end

    // ------------------------------------------------------------
    // Core domain: drained-cell toggle from link side
    // ------------------------------------------------------------
    logic take_tgl;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            take_s1 <= 1'b0;
            take_s2 <= 1'b0;
            take_s3 <= 1'b0;
        end else if (i_ce) begin
            take_s1 <= take_tgl;
            take_s2 <= take_s1;
            take_s3 <= take_s2;
        end
    end

    // ------------------------------------------------------------
    // Core domain: cell pending handoff
    // ------------------------------------------------------------
    logic pend;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cell_tgl <= 1'b0;
            pend <= 1'b0;
            o_cell_taken <= 1'b0;
        end else if (i_ce) begin
            o_cell_taken <= take_s3;
            if (take_s2 != take_s3) begin
                pend <= 1'b0;
            end
            if (i_cell_load && !pend && strap) begin
                cell_tgl <= !cell_tgl;
                pend <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    logic strap_l1, strap_l2;
    logic cell_l1, cell_l2, cell_seen;
    logic [4:0] addr;
    logic enb_n;
    logic sending;
    logic [5:0] idx;

    always_ff @(posedge i_tx_cell_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap_l1 <= 1'b0;
            strap_l2 <= 1'b0;
            cell_l1 <= 1'b0;
            cell_l2 <= 1'b0;
            addr <= ACS_NULL_ADDR;
            enb_n <= 1'b1;
        end else begin
            strap_l1 <= strap;
            strap_l2 <= strap_l1;
            cell_l1 <= cell_tgl;
            cell_l2 <= cell_l1;
            addr <= i_tx_slave_select_addr;
            enb_n <= i_tx_transfer_enable_n;
        end
    end

    wire selected = strap_l2 && (addr == MY_ADDR);
    wire ready_now = strap_l2 && (cell_l2 != cell_seen);
    wire start_now = !sending && !enb_n && selected && ready_now;
    wire last_byte = (idx == 6'(CELL_LEN));

    // ------------------------------------------------------------
    // Link domain: cell sequencer
    // ------------------------------------------------------------

    always_ff @(posedge i_tx_cell_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cell_seen <= 1'b0;
            take_tgl <= 1'b0;
            sending <= 1'b0;
            idx <= '0;
        end else begin
            if (start_now) begin
                sending <= 1'b1;
                idx <= 6'h01;
            end else if (sending && !enb_n) begin
                if (last_byte) begin
                    sending <= 1'b0;
                    cell_seen <= cell_l2;
                    take_tgl <= !take_tgl;
                    idx <= '0;
                end else begin
                    idx <= idx + 6'h01;
                end
            end else if (!strap_l2) begin
                sending <= 1'b0;
                idx <= '0;
            end
        end
    end

    // Index leads the byte by one clock, so no stage of its own
    assign o_cell_rd_idx = idx;

    // ------------------------------------------------------------
    // Link domain: output stage
    // ------------------------------------------------------------

    always_ff @(posedge i_tx_cell_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_link <= '0;
            o_link_oe_n <= 1'b1;
        end else begin
            o_link_oe_n <= !selected;
            o_link.ready <= ready_now && !sending && selected;
            if (!strap_l2) begin
                o_link <= '0;
            end else if (start_now) begin
                o_link.soc <= 1'b1;
                o_link.data <= i_cell_byte.data;
            end else if (sending && !enb_n && !last_byte) begin
                o_link.soc <= 1'b0;
                o_link.data <= i_cell_byte.data;
            end else begin
                o_link.soc <= 1'b0;
                o_link.data <= ACS_IDLE_BYTE;
            end
        end
    end
endmodule

// ### test/acs_tx_port_props.sv
`timescale 1ns/1ps
// ----
// Link and address-pin select checks
// ----
module acs_tx_port_props #(parameter logic [4:0] MY_ADDR = 5'h01) (
    input wire logic i_mclk, // Core clock
    input wire logic i_sys_rst, // Reset
    input wire logic i_cell_port_enable_strap, // Strap
    input wire logic i_tx_cell_clock, // Link clock
    input wire logic i_tx_transfer_enable_n, // Enable
    input wire logic [4:0] i_tx_slave_select_addr, // Address
    input wire acs_pkg::acs_link_out_t o_link, // Link outputs
    input wire logic o_link_oe_n, // Drive enable
    input wire logic o_serial_port_one_sel // Serial select
);
    import acs_pkg::*;
    soc_cause_a: assert property (@(posedge i_tx_cell_clock)
        disable iff (i_sys_rst) o_link.soc |-> $past(o_link.ready, 2)
        && $past(!i_tx_transfer_enable_n, 2)
        && $past(i_tx_slave_select_addr, 2) == MY_ADDR)
        else $error("start without request");
    soc_single_a: assert property (@(posedge i_tx_cell_clock)
        disable iff (i_sys_rst) o_link.soc |=> !o_link.soc)
        else $error("start longer than one byte");
    bus_release_a: assert property (@(posedge i_tx_cell_clock)
        disable iff (i_sys_rst)
        (i_tx_slave_select_addr != MY_ADDR) [*2] |=> o_link_oe_n)
        else $error("driving while unselected");
    tie_off_a: assert property (@(posedge i_tx_cell_clock)
        disable iff (i_sys_rst) o_serial_port_one_sel |-> o_link == '0)
        else $error("outputs active while port off");
    addr_mux_a: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        i_cell_port_enable_strap [*6] |-> !o_serial_port_one_sel)
        else $error("address pins left to serial port");
    soc_drive_a: assert property (@(posedge i_tx_cell_clock)
        disable iff (i_sys_rst) o_link.soc |-> !o_link_oe_n)
        else $error("start of cell while not driving");
endmodule
bind acs_tx_port acs_tx_port_props #(.MY_ADDR(MY_ADDR)) u_props (.*);

// ### test/acs_master_model.sv
`timescale 1ns/1ps
module acs_master_model (
    input wire logic i_tx_cell_clock, // Link clock
    input wire logic i_want, // Request a cell
    input wire logic [4:0] i_addr, // Slave to select
    output logic o_enb_n = 1'h1, // Enable, low
    output logic [4:0] o_addr = 5'h1F // Address pins
);
    // Request and select change just after the rising edge
    always @(posedge i_tx_cell_clock) begin
        o_enb_n <= !i_want;
        o_addr <= i_addr;
    end
endmodule

// ### test/tb_atm_cell_slave_tx_port.sv
`timescale 1ns/1ps
module tb_atm_cell_slave_tx_port;
    import acs_pkg::*;
    logic mclk = 0, lclk = 0, rst = 1, strap = 0, load = 0, want = 0;
    logic [4:0] sel = 5'h1F, pin_addr;
    logic enb_n, taken, oe_n, ser;
    logic [5:0] idx;
    acs_link_out_t lnk;
    acs_byte_t cb;
    int failures = 0, num_checks = 0;
    always #12.5 mclk = ~mclk;
    initial begin
        #7;
        forever #62.5 lclk = ~lclk;
    end
    assign cb = {idx == 6'h00, 8'hA0 + {2'h0, idx}};
    acs_tx_port #(.CELL_LEN(8)) u_acs_tx_port (.i_mclk(mclk),
        .i_sys_rst(rst), .i_ce(1'h1), .i_cell_port_enable_strap(strap),
        .i_cell_load(load), .i_cell_byte(cb), .o_cell_rd_idx(idx),
        .o_cell_taken(taken), .i_tx_cell_clock(lclk),
        .i_tx_transfer_enable_n(enb_n), .i_tx_slave_select_addr(pin_addr),
        .o_link(lnk), .o_link_oe_n(oe_n), .o_serial_port_one_sel(ser));
    acs_master_model u_acs_master_model (.i_tx_cell_clock(lclk),
        .i_want(want), .i_addr(sel), .o_enb_n(enb_n), .o_addr(pin_addr));
    task chk(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task do_reset(input logic s);
        rst = 1;
        strap = s;
        repeat (12) @(negedge mclk);
        rst = 0;
        repeat (6) @(negedge mclk);
    endtask
    task wait_bit(input int b);
        int n;
        n = 0;
        while (lnk[b] !== 1'h1) begin
            @(negedge lclk);
            n++;
            if (n > 40) begin
                failures++;
                $display("[ERR] %0t wait timed out", $time);
                end_of_test;
            end
        end
    endtask
    task test_off;
        do_reset(0);
        sel = 5'h01;
        want = 1;
        repeat (10) @(negedge lclk);
        chk(lnk, 10'h000);
        chk({9'h0, ser}, 10'h001);
        chk({9'h0, oe_n}, 10'h001);
        want = 0;
        $display("port off done");
    endtask
    task test_cell;
        do_reset(1);
        chk({ser, lnk.ready}, 10'h000);
        load = 1;
        @(negedge mclk);
        load = 0;
        wait_bit(9);
        want = 1;
        wait_bit(8);
        chk({1'h0, oe_n, lnk[7:0]}, 10'h0A0);
        for (int i = 1; i < 8; i++) begin
            @(negedge lclk);
            chk({1'h0, lnk[8:0]}, {2'h0, 8'(8'hA0 + i)});
        end
        want = 0;
        repeat (4) @(negedge lclk);
        chk({9'h0, lnk.ready}, 10'h000);
        chk({9'h0, taken}, 10'h001);
        $display("cell done");
    endtask
    task test_unsel;
        sel = 5'h02;
        repeat (4) @(negedge lclk);
        chk({9'h0, oe_n}, 10'h001);
        $display("unselected done");
    endtask
    initial begin
        test_off;
        test_cell;
        test_unsel;
        end_of_test;
    end
endmodule
